// file: tb/ppfs_periph_model.sv
// Model of the peripherals and pads around port 0 and port 2
`timescale 1ns/10ps
module ppfs_periph_model (
	input  wire logic       clk_i,   // Clock
	output logic            osc_o,   // Oscillator clock
	output logic            clka_o,  // Clock output A
	output logic            sclk_o,  // Serial clock value
	output logic            scloe_o, // Serial clock enable
	output logic            sdo_o,   // Serial data out
	output logic      [3:0] p0_o,    // Port 0 pad levels
	output logic      [3:0] p2_o     // Port 2 pad levels
);
	// Osc toggles every cycle so a stale osc route never matches; the other lines take new random values each cycle
	initial begin
		{osc_o, clka_o, sclk_o, scloe_o, sdo_o, p0_o, p2_o} = 13'h0;
		forever begin
			@(posedge clk_i);
			osc_o <= ~osc_o;
			{clka_o, sclk_o, scloe_o, sdo_o, p0_o, p2_o} <= 12'($urandom);
		end
	end
endmodule

// file: tb/ppfs_top_assertions.sv
// Checker of register and pin routing behaviour at the selector top
`timescale 1ns/10ps
module ppfs_top_chk (
	input wire logic       CLK_I, RESET_N_I, WR_I, RD_I,    // Clock, reset, strobes
	input wire logic [15:0] ADDR_I,                         // Address
	input wire logic [7:0]  WDATA_I, RDATA_O, P0_FSEL_O,    // Data and select
	input wire logic [3:0]  P0_OUT_I, P0_OEN_I, P0_PIN_IN_I, P2_PIN_IN_I, // Port side
	input wire logic [3:0]  P0_PIN_OUT_O, P0_PIN_OE_O, P2_IN_O, PORT2_IN_EN_BITS_O, // Pads
	input wire logic        LOW_FREQ_OSC_OUT_I, CLOCK_OUT_A_I, SERIAL_DATA_OUT_I, // Drives
	input wire logic        EXT_TIMER_CLOCK_IN_O, SERIAL_DATA_IN_O // Peripheral inputs
);
	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence s_wr_fsel; WR_I && ADDR_I == 16'h52a0; endsequence
	sequence s_rd_ien; RD_I && ADDR_I == 16'h522a; endsequence
	property p_wr_fsel; s_wr_fsel |=> P0_FSEL_O == $past(WDATA_I); endproperty
	a_wr_fsel: assert property (p_wr_fsel) else $error("select write lost");
	property p_rd_ien; s_rd_ien |=> RDATA_O == {4'h0, $past(PORT2_IN_EN_BITS_O)}; endproperty
	a_rd_ien: assert property (p_rd_ien) else $error("enable readback wrong");
	property p_p2_gate; RESET_N_I |=> P2_IN_O == ($past(P2_PIN_IN_I) & $past(PORT2_IN_EN_BITS_O)); endproperty
	a_p2_gate: assert property (p_p2_gate) else $error("port 2 gating wrong");
	// ------------------------------------------------------------
	// Pin routing, one cycle behind the select value
	// ------------------------------------------------------------
	property p_pin3_osc; P0_FSEL_O[7:6] == 2'h3 |=> P0_PIN_OUT_O[3] == $past(LOW_FREQ_OSC_OUT_I) && P0_PIN_OE_O[3]; endproperty
	a_pin3_osc: assert property (p_pin3_osc) else $error("pin 3 osc route wrong");
	property p_pin3_tmr; P0_FSEL_O[7:6] == 2'h1 |=> EXT_TIMER_CLOCK_IN_O == $past(P0_PIN_IN_I[3]) && !P0_PIN_OE_O[3]; endproperty
	a_pin3_tmr: assert property (p_pin3_tmr) else $error("pin 3 timer route wrong");
	property p_pin2_clka; P0_FSEL_O[5:4] == 2'h2 |=> P0_PIN_OUT_O[2] == $past(CLOCK_OUT_A_I) && P0_PIN_OE_O[2]; endproperty
	a_pin2_clka: assert property (p_pin2_clka) else $error("pin 2 clock route wrong");
	property p_pin1_sout; P0_FSEL_O[3:2] == 2'h1 |=> P0_PIN_OUT_O[1] == $past(SERIAL_DATA_OUT_I) && P0_PIN_OE_O[1]; endproperty
	a_pin1_sout: assert property (p_pin1_sout) else $error("pin 1 serial route wrong");
	property p_pin0_sin; P0_FSEL_O[1:0] == 2'h1 |=> SERIAL_DATA_IN_O == $past(P0_PIN_IN_I[0]) && !P0_PIN_OE_O[0]; endproperty
	a_pin0_sin: assert property (p_pin0_sin) else $error("pin 0 serial route wrong");
	property p_port; RESET_N_I && P0_FSEL_O[1:0] == 2'h0 |=> P0_PIN_OE_O[0] == $past(P0_OEN_I[0]); endproperty
	a_port: assert property (p_port) else $error("pin 0 port drive wrong");
endmodule

bind ppfs_top ppfs_top_chk i_ppfs_top_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .WR_I(WR_I), .RD_I(RD_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .P0_FSEL_O(P0_FSEL_O), .P0_OUT_I(P0_OUT_I),
	.P0_OEN_I(P0_OEN_I), .P0_PIN_IN_I(P0_PIN_IN_I), .P2_PIN_IN_I(P2_PIN_IN_I), .P0_PIN_OUT_O(P0_PIN_OUT_O),
	.P0_PIN_OE_O(P0_PIN_OE_O), .P2_IN_O(P2_IN_O), .PORT2_IN_EN_BITS_O(PORT2_IN_EN_BITS_O),
	.LOW_FREQ_OSC_OUT_I(LOW_FREQ_OSC_OUT_I), .CLOCK_OUT_A_I(CLOCK_OUT_A_I), .SERIAL_DATA_OUT_I(SERIAL_DATA_OUT_I),
	.EXT_TIMER_CLOCK_IN_O(EXT_TIMER_CLOCK_IN_O), .SERIAL_DATA_IN_O(SERIAL_DATA_IN_O));

// file: tb/ppfs_top_tb.sv
// Self-checking bench of the port pin function selector
`timescale 1ns/10ps
module ppfs_top_tb;
	logic        clk, rst_n, wr, rd, osc, clka, sclk, scloe, sdo, etc, sci, sdi, rd_d, pin_ok;
	logic [15:0] addr, in_exp;
	logic [7:0]  wdata, rdata, fsel, sel_m, ien_m, pin_exp, exp_q[$];
	logic [3:0]  p0_out, p0_oen, p0_pad, p2_pad, pout, poe, pin_lv, p2_in, ien, ien_s;
	int          failures, compares;
	ppfs_periph_model i_ppfs_periph_model (.clk_i(clk), .osc_o(osc), .clka_o(clka), .sclk_o(sclk),
		.scloe_o(scloe), .sdo_o(sdo), .p0_o(p0_pad), .p2_o(p2_pad));
	ppfs_top i_ppfs_top (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .P0_OUT_I(p0_out), .P0_OEN_I(p0_oen), .LOW_FREQ_OSC_OUT_I(osc), .CLOCK_OUT_A_I(clka),
		.SER_CLK_OUT_I(sclk), .SER_CLK_OE_I(scloe), .SERIAL_DATA_OUT_I(sdo), .P0_PIN_IN_I(p0_pad),
		.P2_PIN_IN_I(p2_pad), .P0_PIN_OUT_O(pout), .P0_PIN_OE_O(poe), .P0_PORT_IN_O(pin_lv),
		.EXT_TIMER_CLOCK_IN_O(etc), .SER_CLK_IN_O(sci), .SERIAL_DATA_IN_O(sdi), .P2_IN_O(p2_in),
		.PORT2_IN_EN_BITS_O(ien), .P0_FSEL_O(fsel));
	// ------------------------------------------------------------
	// Bus tasks, compare and closing
	// ------------------------------------------------------------
	task chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task chk16(input string n, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Strobe left up after its edge; the next call or the caller lowers it, so no signal is set twice per step
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		wr    <= 1'b1;
		rd    <= 1'b0;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		if (a == ppfs_pkg::ADDR_P0_FSEL) sel_m = d;
		if (a == ppfs_pkg::ADDR_PORT2_IN_EN) ien_s = d[3:0];
	endtask
	task rd_reg(input logic [15:0] a, input logic [7:0] e);
		rd   <= 1'b1;
		wr   <= 1'b0;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
	endtask
	task wrap_up;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Expected pin drive from the shadow select and the drives now present
	function automatic logic [7:0] pins(input logic [7:0] f);
		logic [3:0] o, e;
		o = p0_out;
		e = p0_oen;
		if (f[1:0] != 2'h0) {o[0], e[0]} = 2'h0;
		if (f[3:2] != 2'h0) {o[1], e[1]} = (f[3:2] == 2'h1) ? {sdo, 1'b1} : 2'h0;
		if (f[5:4] != 2'h0) {o[2], e[2]} = (f[5:4] == 2'h1) ? {sclk, scloe} : (f[5:4] == 2'h2) ? {clka, 1'b1} : 2'h0;
		if (f[7:6] != 2'h0) {o[3], e[3]} = (f[7:6] == 2'h3) ? {osc, 1'b1} : 2'h0;
		return {o, e};
	endfunction
	// Expected peripheral inputs, raw port levels and gated port 2 levels
	function automatic logic [15:0] ins(input logic [7:0] f, input logic [3:0] en);
		logic e3, s2, s0;
		e3 = (f[7:6] == 2'h1) ? p0_pad[3] : 1'b0;
		s2 = (f[5:4] == 2'h1) ? p0_pad[2] : 1'b0;
		s0 = (f[1:0] == 2'h1) ? p0_pad[0] : 1'b0;
		return {5'h00, e3, s2, s0, p0_pad, p2_pad & en};
	endfunction
	// Monitor: read data one cycle after the strobe, pins one cycle after select
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d) chk8("rdata", exp_q.pop_front(), rdata);
		if (pin_ok) chk8("pins", pin_exp, {pout, poe});
		if (pin_ok) chk16("inputs", in_exp, {5'h00, etc, sci, sdi, pin_lv, p2_in});
		if (rst_n) chk16("regs", {4'h0, ien_s, sel_m}, {4'h0, ien, fsel});
		pin_exp = pins(sel_m);
		in_exp = ins(sel_m, ien_s);
		pin_ok = rst_n;
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, wr, rd, addr, wdata, p0_out, p0_oen, sel_m} = 0;
		failures = 0;
		compares = 0;
		void'($urandom(32'h5943f918));
		for (int r = 0; r < 2; r++) begin
			rst_n <= 1'b0;
			sel_m = 8'h00;
			ien_s = 4'hf;
			repeat (6) @(posedge clk);
			rst_n <= 1'b1;
			rd_reg(ppfs_pkg::ADDR_PORT2_IN_EN, 8'h0f);
			rd_reg(ppfs_pkg::ADDR_P0_FSEL, 8'h00);
			rd_reg(16'h5229, 8'h00);
			for (int i = 0; i < 256; i++) begin
				ien_m = 8'($urandom);
				wr_reg(ppfs_pkg::ADDR_P0_FSEL, 8'(i));
				wr_reg(ppfs_pkg::ADDR_PORT2_IN_EN, ien_m);
				wr_reg(16'h52a4, 8'hff);
				rd_reg(ppfs_pkg::ADDR_PORT2_IN_EN, ien_m & 8'h0f);
				rd_reg(ppfs_pkg::ADDR_P0_FSEL, 8'(i));
				wr <= 1'b0;
				rd <= 1'b0;
				{p0_out, p0_oen} <= 8'($urandom);
				repeat (2) @(posedge clk);
			end
		end
		repeat (3) @(posedge clk);
		wrap_up();
	end
endmodule

// file: verilog/ppfs_pin_sel.sv
// One pin's function multiplexer: picks drive by a two-bit code
`timescale 1ns/10ps
module ppfs_pin_sel (
	input  wire logic                 CLK_I,     // Clock
	input  wire logic                 RESET_N_I, // Sync reset, active low
	input  wire logic [1:0]           sel_i,     // Function code
	input  wire ppfs_pkg::ppfs_drive_t port_i,   // General port drive
	input  wire ppfs_pkg::ppfs_drive_t f1_i,     // Drive for code 1
	input  wire ppfs_pkg::ppfs_drive_t f2_i,     // Drive for code 2
	input  wire ppfs_pkg::ppfs_drive_t f3_i,     // Drive for code 3
	output ppfs_pkg::ppfs_drive_t      pin_o     // Registered pin drive
);
	ppfs_pkg::ppfs_drive_t next_pin;
	ppfs_pkg::ppfs_drive_t pin;

	// Route drive by code; reserved codes are given tristate drive by the caller
	always_comb begin
		unique case (sel_i)
			ppfs_pkg::FN_PORT: next_pin = port_i;
			ppfs_pkg::FN_ONE:  next_pin = f1_i;
			ppfs_pkg::FN_TWO:  next_pin = f2_i;
			ppfs_pkg::FN_THR:  next_pin = f3_i;
		endcase
	end

	// Register so the top's outputs come from flops
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			pin <= '0;
		end else begin
			pin <= next_pin;
		end
	end

	assign pin_o = pin;
endmodule

// file: verilog/ppfs_pkg.sv
// Package of constants and carrier types for the port pin function selector
package ppfs_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_PORT2_IN_EN = 16'h522a;
	localparam logic [15:0] ADDR_P0_FSEL     = 16'h52a0;
	localparam logic [7:0]  RST_PORT2_IN_EN  = 8'h0f;
	localparam logic [7:0]  RST_P0_FSEL      = 8'h00;
	localparam logic [7:0]  MASK_PORT2_IN_EN = 8'h0f;
	localparam logic [7:0]  READ_UNMAPPED = 8'h00;

	// ------------------------------------------------------------
	// Field positions of the function select register
	// ------------------------------------------------------------
	localparam int SEL_W    = 2;
	localparam int PIN0_LSB = 0;
	localparam int PIN1_LSB = 2;
	localparam int PIN2_LSB = 4;
	localparam int PIN3_LSB = 6;

	// Function codes
	localparam logic [1:0] FN_PORT = 2'h0;
	localparam logic [1:0] FN_ONE  = 2'h1;
	localparam logic [1:0] FN_TWO  = 2'h2;
	localparam logic [1:0] FN_THR  = 2'h3;

	// One pin's drive: value and output enable
	typedef struct packed {
		logic val;
		logic oe;
	} ppfs_drive_t;
endpackage

// file: verilog/ppfs_top.sv
// Top of the port pin function selector with its register slave
`timescale 1ns/10ps
module ppfs_top (
	input  wire logic        CLK_I,          // Peripheral clock, 50 MHz
	input  wire logic        RESET_N_I,      // Sync reset, active low
	input  wire logic [15:0] ADDR_I,         // Register byte address
	input  wire logic [7:0]  WDATA_I,        // Write data
	input  wire logic        WR_I,           // Write strobe
	input  wire logic        RD_I,           // Read strobe
	output logic      [7:0]  RDATA_O,        // Read data, cycle after strobe
	input  wire logic [3:0]  P0_OUT_I,       // Port 0 low output data
	input  wire logic [3:0]  P0_OEN_I,       // Port 0 low output enables
	input  wire logic        LOW_FREQ_OSC_OUT_I, // Oscillator clock to pin 3
	input  wire logic        CLOCK_OUT_A_I,  // Clock output A to pin 2
	input  wire logic        SER_CLK_OUT_I,  // Serial clock line value
	input  wire logic        SER_CLK_OE_I,   // Serial clock drive enable
	input  wire logic        SERIAL_DATA_OUT_I, // Serial data out to pin 1
	input  wire logic [3:0]  P0_PIN_IN_I,    // Port 0 low pin levels
	input  wire logic [3:0]  P2_PIN_IN_I,    // Port 2 pin levels
	output logic      [3:0]  P0_PIN_OUT_O,   // Port 0 low pin values
	output logic      [3:0]  P0_PIN_OE_O,    // Port 0 low pin enables
	output logic      [3:0]  P0_PORT_IN_O,   // Levels to port logic
	output logic             EXT_TIMER_CLOCK_IN_O, // Pin 3 to timer
	output logic             SER_CLK_IN_O,   // Pin 2 to serial clock in
	output logic             SERIAL_DATA_IN_O, // Pin 0 to serial in
	output logic      [3:0]  P2_IN_O,        // Gated port 2 levels
	output logic      [3:0]  PORT2_IN_EN_BITS_O, // Port 2 input enables
	output logic      [7:0]  P0_FSEL_O       // Function select value
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [3:0] port2_in_en_bits;
	logic [3:0] next_port2_in_en_bits;
	logic [1:0] pin3_func_sel;
	logic [1:0] pin2_func_sel;
	logic [1:0] pin1_func_sel;
	logic [1:0] pin0_func_sel;
	logic [7:0] next_fsel;
	logic [7:0] fsel;
	logic [7:0] rdata;
	logic [7:0] next_rdata;

	assign fsel = {pin3_func_sel, pin2_func_sel, pin1_func_sel, pin0_func_sel};

	// Write decode and read mux; unmapped reads return zero
	always_comb begin
		next_port2_in_en_bits = port2_in_en_bits;
		next_fsel             = fsel;
		next_rdata            = rdata;
		if (WR_I && ADDR_I == ppfs_pkg::ADDR_PORT2_IN_EN) begin
			next_port2_in_en_bits = WDATA_I[3:0];
		end
		if (WR_I && ADDR_I == ppfs_pkg::ADDR_P0_FSEL) begin
			next_fsel = WDATA_I;
		end
		if (RD_I) begin
			if (ADDR_I == ppfs_pkg::ADDR_PORT2_IN_EN) begin
				next_rdata = {4'h0, port2_in_en_bits} & ppfs_pkg::MASK_PORT2_IN_EN;
			end else if (ADDR_I == ppfs_pkg::ADDR_P0_FSEL) begin
				next_rdata = fsel;
			end else begin
				next_rdata = ppfs_pkg::READ_UNMAPPED;
			end
		end
	end

	// Registers; read data hold their value between reads
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			port2_in_en_bits <= ppfs_pkg::RST_PORT2_IN_EN[3:0];
			pin3_func_sel    <= ppfs_pkg::RST_P0_FSEL[ppfs_pkg::PIN3_LSB +: ppfs_pkg::SEL_W];
			pin2_func_sel    <= ppfs_pkg::RST_P0_FSEL[ppfs_pkg::PIN2_LSB +: ppfs_pkg::SEL_W];
			pin1_func_sel    <= ppfs_pkg::RST_P0_FSEL[ppfs_pkg::PIN1_LSB +: ppfs_pkg::SEL_W];
			pin0_func_sel    <= ppfs_pkg::RST_P0_FSEL[ppfs_pkg::PIN0_LSB +: ppfs_pkg::SEL_W];
			rdata            <= 8'h00;
		end else begin
			port2_in_en_bits <= next_port2_in_en_bits;
			pin3_func_sel    <= next_fsel[ppfs_pkg::PIN3_LSB +: ppfs_pkg::SEL_W];
			pin2_func_sel    <= next_fsel[ppfs_pkg::PIN2_LSB +: ppfs_pkg::SEL_W];
			pin1_func_sel    <= next_fsel[ppfs_pkg::PIN1_LSB +: ppfs_pkg::SEL_W];
			pin0_func_sel    <= next_fsel[ppfs_pkg::PIN0_LSB +: ppfs_pkg::SEL_W];
			rdata            <= next_rdata;
		end
	end

	assign RDATA_O            = rdata;
	assign PORT2_IN_EN_BITS_O = port2_in_en_bits;
	assign P0_FSEL_O          = fsel;

	// ------------------------------------------------------------
	// Output multiplexers, one per pin
	// ------------------------------------------------------------
	ppfs_pkg::ppfs_drive_t port_drv [4];
	ppfs_pkg::ppfs_drive_t f1_drv   [4];
	ppfs_pkg::ppfs_drive_t f2_drv   [4];
	ppfs_pkg::ppfs_drive_t f3_drv   [4];
	ppfs_pkg::ppfs_drive_t pin_drv  [4];
	logic [1:0]            sel      [4];
	ppfs_pkg::ppfs_drive_t off;

	// Reserved and input-only functions leave the pin undriven
	assign off = '{val: 1'b0, oe: 1'b0};

	assign sel[0] = pin0_func_sel;
	assign sel[1] = pin1_func_sel;
	assign sel[2] = pin2_func_sel;
	assign sel[3] = pin3_func_sel;

	// Peripheral drive per pin and code
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			port_drv[i] = '{val: P0_OUT_I[i], oe: P0_OEN_I[i]};
			f1_drv[i]   = off;
			f2_drv[i]   = off;
			f3_drv[i]   = off;
		end
		f1_drv[1] = '{val: SERIAL_DATA_OUT_I, oe: 1'b1};
		f1_drv[2] = '{val: SER_CLK_OUT_I, oe: SER_CLK_OE_I};
		f2_drv[2] = '{val: CLOCK_OUT_A_I, oe: 1'b1};
		f3_drv[3] = '{val: LOW_FREQ_OSC_OUT_I, oe: 1'b1};
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			ppfs_pin_sel u_sel (
				.CLK_I     (CLK_I),
				.RESET_N_I (RESET_N_I),
				.sel_i     (sel[g]),
				.port_i    (port_drv[g]),
				.f1_i      (f1_drv[g]),
				.f2_i      (f2_drv[g]),
				.f3_i      (f3_drv[g]),
				.pin_o     (pin_drv[g])
			);
			assign P0_PIN_OUT_O[g] = pin_drv[g].val;
			assign P0_PIN_OE_O[g]  = pin_drv[g].oe;
		end
	endgenerate

	// ------------------------------------------------------------
	// Input routing
	// ------------------------------------------------------------
	logic [3:0] next_p0_port_in;
	logic [3:0] p0_port_in;
	logic       next_ext_clk;
	logic       ext_clk;
	logic       next_sclk_in;
	logic       sclk_in;
	logic       next_sin;
	logic       sin;
	logic [3:0] next_p2_in;
	logic [3:0] p2_in;

	// Peripheral inputs see the pin only when selected, else idle low
	always_comb begin
		next_p0_port_in = P0_PIN_IN_I;
		next_ext_clk    = (pin3_func_sel == ppfs_pkg::FN_ONE) ? P0_PIN_IN_I[3] : 1'b0;
		next_sclk_in    = (pin2_func_sel == ppfs_pkg::FN_ONE) ? P0_PIN_IN_I[2] : 1'b0;
		next_sin        = (pin0_func_sel == ppfs_pkg::FN_ONE) ? P0_PIN_IN_I[0] : 1'b0;
		next_p2_in      = P2_PIN_IN_I & port2_in_en_bits;
	end

	// Registered so input paths are one flop deep
	always_ff @(posedge CLK_I) begin
		if (!RESET_N_I) begin
			p0_port_in <= 4'h0;
			ext_clk    <= 1'b0;
			sclk_in    <= 1'b0;
			sin        <= 1'b0;
			p2_in      <= 4'h0;
		end else begin
			p0_port_in <= next_p0_port_in;
			ext_clk    <= next_ext_clk;
			sclk_in    <= next_sclk_in;
			sin        <= next_sin;
			p2_in      <= next_p2_in;
		end
	end

	assign P0_PORT_IN_O         = p0_port_in;
	assign EXT_TIMER_CLOCK_IN_O = ext_clk;
	assign SER_CLK_IN_O         = sclk_in;
	assign SERIAL_DATA_IN_O     = sin;
	assign P2_IN_O              = p2_in;
endmodule
